// ==== dwb_buf.sv ====
// package of shared constants and the two-entry beat buffer
package dwb_pkg;
   // burst field of mode_register_zero bits 1:0
   localparam logic [1:0] BURST_FIXED_EIGHT = 2'h0;
   localparam logic [1:0] BURST_ON_THE_FLY  = 2'h1;
   localparam logic [1:0] BURST_FIXED_CHOP  = 2'h2;
   // device organisation codes
   localparam logic [1:0] ORG_X4            = 2'h0;
   localparam logic [1:0] ORG_X8            = 2'h1;
   localparam logic [1:0] ORG_X16           = 2'h2;
   // beat counts
   localparam logic [3:0] BEATS_EIGHT       = 4'h8;
   localparam logic [3:0] BEATS_FOUR        = 4'h4;
   // widths
   localparam int         DATA_W            = 16;
   localparam int         LANES             = 2;
   localparam int         COL_W             = 10;
   localparam int         BANK_W            = 4;
   localparam int         ENTRY_W           = DATA_W + LANES + BANK_W + COL_W;
   // timing figures
   localparam int         CLK_PERIOD_NS     = 100;
   localparam int         STROBE_PERIOD_NS  = 800;
   localparam int         STROBE_HALF_CYC   = (STROBE_PERIOD_NS / 2) / CLK_PERIOD_NS;
   // reset values
   localparam logic [5:0] LAT_RESET         = 6'h00;
   localparam logic [3:0] BEAT_RESET        = 4'h0;
   // state codes
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LAT  = 2'b01,
      ST_DATA = 2'b10
   } dwb_state_t;
endpackage : dwb_pkg

`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// two-entry buffer; head entry and flags come straight from flip-flops
module dwb_buf #(
   parameter int WIDTH = 32
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             valid_in,
   output logic                  ready_in,
   input  wire logic [WIDTH-1:0] data_in,
   output logic                  valid_out,
   input  wire logic             ready_out,
   output logic      [WIDTH-1:0] data_out
);
   logic [WIDTH-1:0] slot0_r, slot0_nxt, slot1_r, slot1_nxt;
   logic             v0_r, v0_nxt, v1_r, v1_nxt;
   logic             push, pop;

   // pop shifts slot one forward, push fills the first free slot
   always_comb begin
      push      = valid_in && !v1_r;
      pop       = v0_r && ready_out;
      slot0_nxt = slot0_r;
      slot1_nxt = slot1_r;
      v0_nxt    = v0_r;
      v1_nxt    = v1_r;
      if (pop) begin
         slot0_nxt = slot1_r;
         v0_nxt    = v1_r;
         v1_nxt    = 1'b0;
      end
      if (push) begin
         if (!v0_nxt) begin
            slot0_nxt = data_in;
            v0_nxt    = 1'b1;
         end else begin
            slot1_nxt = data_in;
            v1_nxt    = 1'b1;
         end
      end
   end

   // register the buffer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         slot0_r <= '0;
         slot1_r <= '0;
         v0_r    <= 1'b0;
         v1_r    <= 1'b0;
      end else begin
         slot0_r <= slot0_nxt;
         slot1_r <= slot1_nxt;
         v0_r    <= v0_nxt;
         v1_r    <= v1_nxt;
      end
   end

   assign ready_in  = !v1_r;  // full only when both slots hold
   assign valid_out = v0_r;
   assign data_out  = slot0_r;
endmodule : dwb_buf

// ==== dwb_ctrl_model.sv ====
// controller-side model driving strobe, data and mask pins for one burst per go pulse
`timescale 1ns/100ps

module dwb_ctrl_model (
   input  wire logic        go,
   input  wire logic [3:0]  n_edges,
   input  wire logic [15:0] base,
   input  wire logic [1:0]  mask,
   output logic             strobe_in,
   output logic [15:0]      dq_in,
   output logic [1:0]       write_mask_n
);
   // strobe idles low so reset release sees no edge
   initial begin
      strobe_in = 1'b0;
      dq_in = 16'h5a5a;
      write_mask_n = 2'h3;
   end

   // offset of 37 ns keeps the strobe out of phase with clk
   always @(posedge go) begin
      #37;
      for (int i = 0; i < n_edges; i++) begin
         dq_in = base + 16'(i);
         write_mask_n = mask;
         #200;
         strobe_in = ~strobe_in;
         #200;
      end
      // released lines show the inverse of the last beat
      dq_in = ~dq_in;
      write_mask_n = ~write_mask_n;
   end
endmodule : dwb_ctrl_model

// ==== dwb_wp_properties.sv ====
// checker of command, precharge, lane and crc-mode timing at the write path ports
`timescale 1ns/100ps

module dwb_wp_properties (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic [1:0] org_width,
   input wire logic       mask_enable,
   input wire logic       bus_inversion_enable,
   input wire logic       termination_strobe_enable,
   input wire logic       crc_enable,
   input wire logic       wr_cmd,
   input wire logic       addr_a10,
   input wire logic [3:0] cmd_bank,
   input wire logic       arr_valid,
   input wire logic       arr_ready,
   input wire logic [9:0] arr_col,
   input wire logic [1:0] arr_lane_en,
   input wire logic       precharge_start_r,
   input wire logic [3:0] precharge_bank_r,
   input wire logic       burst_done_r,
   input wire logic       busy_r,
   input wire logic       overflow_r,
   input wire logic       crc_persistent_r
);
   logic [3:0] bank_q;
   logic       a10_q;
   logic       eff_mask;

   ////////////////////////////////////////////////////////////////////////////
   // command fields held from the accepted write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         bank_q <= 4'h0;
         a10_q  <= 1'b0;
      end else if (wr_cmd && !busy_r) begin
         bank_q <= cmd_bank;
         a10_q  <= addr_a10;
      end
   end

   // masking only counts when no other pin use is active
   assign eff_mask = mask_enable && !bus_inversion_enable && !termination_strobe_enable
                     && (org_width != dwb_pkg::ORG_X4);

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_cmd_busy; wr_cmd && !busy_r |=> busy_r; endproperty
   a_cmd_busy: assert property (p_cmd_busy) else $error("busy missing after command");
   property p_done_idle; burst_done_r |-> !busy_r && $past(busy_r); endproperty
   a_done_idle: assert property (p_done_idle) else $error("done without busy end");
   property p_pre_done; burst_done_r |-> precharge_start_r == a10_q; endproperty
   a_pre_done: assert property (p_pre_done) else $error("precharge not per a10");
   property p_pre_bank; precharge_start_r |-> burst_done_r && precharge_bank_r == bank_q; endproperty
   a_pre_bank: assert property (p_pre_bank) else $error("precharge bank or moment wrong");
   property p_x4; arr_valid && org_width == dwb_pkg::ORG_X4 |-> arr_lane_en == 2'h1; endproperty
   a_x4: assert property (p_x4) else $error("narrow part masked a lane");
   property p_dbi; arr_valid && bus_inversion_enable && org_width == dwb_pkg::ORG_X16 |-> arr_lane_en == 2'h3;
   endproperty
   a_dbi: assert property (p_dbi) else $error("mask active with inversion");
   property p_crc; 1'b1 |=> crc_persistent_r == $past(crc_enable && eff_mask); endproperty
   a_crc: assert property (p_crc) else $error("crc mode wrong");
   property p_hold; arr_valid && !arr_ready |=> arr_valid && $stable(arr_col) && $stable(arr_lane_en);
   endproperty
   a_hold: assert property (p_hold) else $error("head entry lost while stalled");

   c_pre: cover property (precharge_start_r);
   c_ovf: cover property ($rose(overflow_r));
   c_mask: cover property (arr_valid && arr_ready && arr_lane_en != 2'h3 && org_width == dwb_pkg::ORG_X16);
endmodule : dwb_wp_properties

// ==== dwb_write_path.sv ====
// write-burst path of the memory device: burst selection, masking, auto precharge
//
// Contract
// - accept fixed eight-beat, fixed chop-four, or per-command burst length.
// - on-the-fly mode: A12 low gives chop-four, A12 high gives eight beats.
// - A10 low: plain write, bank stays active after the burst.
// - A10 high: bank precharges automatically once the burst finishes.
// - masking exists on x8 and x16 organisations only, never on x4.
// - mask pin shared with bus inversion and termination strobe; one use at once.
// - masking only on writes; masking and bus inversion are mutually exclusive.
// - mask low on a lane during a beat discards that lane's data.
// - mask high on a lane during a beat stores that lane's data.
// - with write crc on, masking enable picks persistent versus nonpersistent crc.
// - eight beats when burst field is 00, or 01 with A12 high.
// - burst field 10 forces chop-four on every write regardless of A12.
// - write latency equals additive latency plus cas write latency.
`timescale 1ns/100ps

module dwb_write_path (
   input  wire logic                                 clk,
   input  wire logic                                 rst_n,
   // mode settings
   input  wire logic [1:0]                           burst_mode,
   input  wire logic [4:0]                           additive_latency,
   input  wire logic [4:0]                           cas_write_latency,
   input  wire logic [1:0]                           org_width,
   input  wire logic                                 mask_enable,
   input  wire logic                                 bus_inversion_enable,
   input  wire logic                                 termination_strobe_enable,
   input  wire logic                                 crc_enable,
   // write command, on clk
   input  wire logic                                 wr_cmd,
   input  wire logic                                 addr_a10,
   input  wire logic                                 addr_a12,
   input  wire logic [dwb_pkg::BANK_W-1:0]           cmd_bank,
   input  wire logic [dwb_pkg::COL_W-1:0]            cmd_col,
   // link pins, asynchronous to clk
   input  wire logic                                 strobe_in,
   input  wire logic [dwb_pkg::DATA_W-1:0]           dq_in,
   input  wire logic [dwb_pkg::LANES-1:0]            write_mask_n,
   // array write side
   output logic                                      arr_valid,
   input  wire logic                                 arr_ready,
   output logic      [dwb_pkg::DATA_W-1:0]           arr_data,
   output logic      [dwb_pkg::LANES-1:0]            arr_lane_en,
   output logic      [dwb_pkg::BANK_W-1:0]           arr_bank,
   output logic      [dwb_pkg::COL_W-1:0]            arr_col,
   // status
   output logic                                      precharge_start_r,
   output logic      [dwb_pkg::BANK_W-1:0]           precharge_bank_r,
   output logic                                      burst_done_r,
   output logic                                      busy_r,
   output logic                                      overflow_r,
   output logic                                      crc_persistent_r
);
   ////////////////////////////////////////////////////////////////////////////
   // three-flop synchronisers for strobe, data and mask pins
   localparam int PIN_W = 1 + dwb_pkg::DATA_W + dwb_pkg::LANES;
   logic [PIN_W-1:0] pin_s1_r, pin_s2_r, pin_s3_r;
   logic             strobe_stable_r, strobe_stable_nxt;
   logic             beat_edge;

   // stable level updates when second and third stages agree
   always_comb begin
      strobe_stable_nxt = strobe_stable_r;
      beat_edge         = 1'b0;
      if (pin_s2_r[PIN_W-1] == pin_s3_r[PIN_W-1]) begin
         strobe_stable_nxt = pin_s3_r[PIN_W-1];
         beat_edge         = pin_s3_r[PIN_W-1] != strobe_stable_r;
      end
   end

   // synchroniser stages
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_s1_r        <= '0;
         pin_s2_r        <= '0;
         pin_s3_r        <= '0;
         strobe_stable_r <= 1'b0;
      end else begin
         pin_s1_r        <= {strobe_in, write_mask_n, dq_in};
         pin_s2_r        <= pin_s1_r;
         pin_s3_r        <= pin_s2_r;
         strobe_stable_r <= strobe_stable_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode decode
   logic                       mask_on;
   logic [dwb_pkg::LANES-1:0]  lane_present;
   logic                       cmd_eight;
   logic                       cmd_fixed_chop;
   logic [5:0]                 write_lat;

   always_comb begin
      mask_on = mask_enable && !bus_inversion_enable && !termination_strobe_enable &&
                (org_width != dwb_pkg::ORG_X4);
      lane_present = (org_width == dwb_pkg::ORG_X16) ? 2'h3 : 2'h1;
      cmd_eight = (burst_mode == dwb_pkg::BURST_FIXED_EIGHT) ||
                  ((burst_mode == dwb_pkg::BURST_ON_THE_FLY) && addr_a12);
      cmd_fixed_chop = (burst_mode == dwb_pkg::BURST_FIXED_CHOP);
      write_lat = {1'b0, additive_latency} + {1'b0, cas_write_latency};
   end

   ////////////////////////////////////////////////////////////////////////////
   // burst sequencer
   dwb_pkg::dwb_state_t            state_r, state_nxt;
   logic [5:0]                     lat_r, lat_nxt;
   logic [5:0]                     lat_tgt_r, lat_tgt_nxt;
   logic [3:0]                     beat_r, beat_nxt;
   logic [3:0]                     edges_r, edges_nxt;   // strobe edges in burst
   logic [3:0]                     keep_r, keep_nxt;     // beats that are stored
   logic                           ap_r, ap_nxt;
   logic [dwb_pkg::BANK_W-1:0]     bank_r, bank_nxt;
   logic [dwb_pkg::COL_W-1:0]      col_r, col_nxt;
   logic                           pre_nxt, done_nxt, ovf_nxt, crc_nxt;
   logic [dwb_pkg::BANK_W-1:0]     pre_bank_nxt;
   logic                           push;
   logic                           buf_ready;
   logic [dwb_pkg::LANES-1:0]      lane_en;
   logic [dwb_pkg::ENTRY_W-1:0]    entry;

   always_comb begin
      state_nxt    = state_r;
      lat_nxt      = lat_r;
      lat_tgt_nxt  = lat_tgt_r;
      beat_nxt     = beat_r;
      edges_nxt    = edges_r;
      keep_nxt     = keep_r;
      ap_nxt       = ap_r;
      bank_nxt     = bank_r;
      col_nxt      = col_r;
      pre_nxt      = 1'b0;
      pre_bank_nxt = precharge_bank_r;
      done_nxt     = 1'b0;
      ovf_nxt      = overflow_r;
      push         = 1'b0;
      crc_nxt      = crc_enable && mask_on;
      lane_en      = mask_on ? (pin_s3_r[dwb_pkg::DATA_W +: dwb_pkg::LANES] & lane_present)
                             : lane_present;
      entry        = {pin_s3_r[dwb_pkg::DATA_W-1:0], lane_en, bank_r,
                      col_r + {{(dwb_pkg::COL_W-4){1'b0}}, beat_r}};
      case (state_r)
         dwb_pkg::ST_IDLE: begin
            if (wr_cmd) begin
               state_nxt   = dwb_pkg::ST_LAT;
               lat_nxt     = dwb_pkg::LAT_RESET;
               lat_tgt_nxt = write_lat;
               beat_nxt    = dwb_pkg::BEAT_RESET;
               edges_nxt   = cmd_fixed_chop ? dwb_pkg::BEATS_FOUR : dwb_pkg::BEATS_EIGHT;
               keep_nxt    = (cmd_eight && !cmd_fixed_chop) ? dwb_pkg::BEATS_EIGHT
                                                            : dwb_pkg::BEATS_FOUR;
               ap_nxt      = addr_a10;
               bank_nxt    = cmd_bank;
               col_nxt     = cmd_col;
            end
         end
         dwb_pkg::ST_LAT: begin
            if (lat_r >= lat_tgt_r) begin
               state_nxt = dwb_pkg::ST_DATA;
            end else begin
               lat_nxt = lat_r + 6'h01;
            end
         end
         dwb_pkg::ST_DATA: begin
            if (beat_edge) begin
               if (beat_r < keep_r) begin
                  push = 1'b1;
                  if (!buf_ready) begin
                     ovf_nxt = 1'b1;  // sticky: the link cannot be stalled
                  end
               end
               beat_nxt = beat_r + 4'h1;
               if (beat_r + 4'h1 == edges_r) begin
                  state_nxt    = dwb_pkg::ST_IDLE;
                  done_nxt     = 1'b1;
                  pre_nxt      = ap_r;
                  pre_bank_nxt = bank_r;
               end
            end
         end
         default: begin
            state_nxt = dwb_pkg::ST_IDLE;
         end
      endcase
   end

   // register the sequencer
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r           <= dwb_pkg::ST_IDLE;
         lat_r             <= dwb_pkg::LAT_RESET;
         lat_tgt_r         <= dwb_pkg::LAT_RESET;
         beat_r            <= dwb_pkg::BEAT_RESET;
         edges_r           <= dwb_pkg::BEAT_RESET;
         keep_r            <= dwb_pkg::BEAT_RESET;
         ap_r              <= 1'b0;
         bank_r            <= '0;
         col_r             <= '0;
         precharge_start_r <= 1'b0;
         precharge_bank_r  <= '0;
         burst_done_r      <= 1'b0;
         busy_r            <= 1'b0;
         overflow_r        <= 1'b0;
         crc_persistent_r  <= 1'b0;
      end else begin
         state_r           <= state_nxt;
         lat_r             <= lat_nxt;
         lat_tgt_r         <= lat_tgt_nxt;
         beat_r            <= beat_nxt;
         edges_r           <= edges_nxt;
         keep_r            <= keep_nxt;
         ap_r              <= ap_nxt;
         bank_r            <= bank_nxt;
         col_r             <= col_nxt;
         precharge_start_r <= pre_nxt;
         precharge_bank_r  <= pre_bank_nxt;
         burst_done_r      <= done_nxt;
         busy_r            <= state_nxt != dwb_pkg::ST_IDLE;
         overflow_r        <= ovf_nxt;
         crc_persistent_r  <= crc_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // beat buffer toward the array
   dwb_buf #(
      .WIDTH (dwb_pkg::ENTRY_W)
   ) u_buf (
      .clk       (clk),
      .rst_n     (rst_n),
      .valid_in  (push),
      .ready_in  (buf_ready),
      .data_in   (entry),
      .valid_out (arr_valid),
      .ready_out (arr_ready),
      .data_out  ({arr_data, arr_lane_en, arr_bank, arr_col})
   );
endmodule : dwb_write_path

// ==== tb.sv ====
// testbench of the write-burst path with a controller model on the link pins
`timescale 1ns/100ps

module tb;
   logic [4:0]  additive_latency, cas_write_latency;
   logic        clk, rst_n, wr_cmd, addr_a10, addr_a12, arr_ready, m_go, strobe_in;
   logic        mask_enable, bus_inversion_enable, termination_strobe_enable, crc_enable;
   logic [1:0]  burst_mode, org_width, m_mask, exp_lane, write_mask_n, arr_lane_en;
   logic [3:0]  cmd_bank, m_n, arr_bank, precharge_bank_r;
   logic [9:0]  cmd_col, arr_col;
   logic [15:0] m_base, dq_in, arr_data;
   logic        arr_valid, precharge_start_r, burst_done_r, busy_r, overflow_r, crc_persistent_r;
   int          n_errors, tests_run, n_got;

   dwb_write_path dut_u (.clk(clk), .rst_n(rst_n), .burst_mode(burst_mode), .additive_latency(additive_latency),
      .cas_write_latency(cas_write_latency), .org_width(org_width), .mask_enable(mask_enable),
      .bus_inversion_enable(bus_inversion_enable), .termination_strobe_enable(termination_strobe_enable),
      .crc_enable(crc_enable), .wr_cmd(wr_cmd), .addr_a10(addr_a10), .addr_a12(addr_a12), .cmd_bank(cmd_bank),
      .cmd_col(cmd_col), .strobe_in(strobe_in), .dq_in(dq_in), .write_mask_n(write_mask_n),
      .arr_valid(arr_valid), .arr_ready(arr_ready), .arr_data(arr_data), .arr_lane_en(arr_lane_en),
      .arr_bank(arr_bank), .arr_col(arr_col), .precharge_start_r(precharge_start_r),
      .precharge_bank_r(precharge_bank_r), .burst_done_r(burst_done_r), .busy_r(busy_r),
      .overflow_r(overflow_r), .crc_persistent_r(crc_persistent_r));
   dwb_ctrl_model ptr_u (.go(m_go), .n_edges(m_n), .base(m_base), .mask(m_mask), .strobe_in(strobe_in),
      .dq_in(dq_in), .write_mask_n(write_mask_n));

   ////////////////////////////////////////////////////////////////////////////
   // clock of 100 ns
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim();
      $display("errors=%0d checks=%0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_sim

   // every word the array takes is compared in column order
   always @(posedge clk) begin
      if (arr_valid === 1'b1 && arr_ready === 1'b1) begin
         check(arr_data, 32'(m_base + 16'(n_got)));
         check(arr_col, 32'(cmd_col + 10'(n_got)));
         check(arr_bank, cmd_bank);
         check(arr_lane_en, exp_lane);
         n_got++;
      end
   end

   // one write burst with its mode levels, then the end-of-burst outputs
   // fl packs a10, a12, mask, inversion, termination strobe, crc and expected precharge
   task automatic run(input logic [1:0] md, org, mk, el, input logic [6:0] fl, input logic [3:0] ne,
                      input int ew);
      int wl;
      burst_mode <= md;
      org_width <= org;
      mask_enable <= fl[4];
      bus_inversion_enable <= fl[3];
      termination_strobe_enable <= fl[2];
      crc_enable <= fl[1];
      addr_a10 <= fl[6];
      addr_a12 <= fl[5];
      cmd_bank <= cmd_bank + 4'h3;
      cmd_col <= cmd_col + 10'h020;
      m_mask <= mk;
      m_n <= ne;
      m_base <= m_base + 16'h1111;
      n_got = 0;
      exp_lane = el;
      @(posedge clk);
      wr_cmd <= 1'b1;
      @(posedge clk);
      wr_cmd <= 1'b0;
      wl = int'(additive_latency) + int'(cas_write_latency);
      repeat (wl - 4) @(posedge clk);
      m_go <= 1'b1;
      @(posedge clk);
      m_go <= 1'b0;
      for (int i = 0; i < 300; i++) begin
         @(posedge clk);
         #1;
         if (burst_done_r === 1'b1) break;
      end
      check(burst_done_r, 1'b1);
      check(busy_r, 1'b0);
      check(precharge_start_r, fl[0]);
      if (fl[0]) check(precharge_bank_r, cmd_bank);
      check(crc_persistent_r, fl[1] & fl[4] & ~fl[3] & ~fl[2] & (org != dwb_pkg::ORG_X4));
      // next command only after burst end
      repeat (4) @(posedge clk);
      check(n_got, ew);
   endtask : run

   task automatic t_eight(); run(dwb_pkg::BURST_FIXED_EIGHT, dwb_pkg::ORG_X16, 2'h3, 2'h3, 7'b0000000, 4'h8, 8);
   endtask : t_eight
   task automatic t_otf_eight(); run(dwb_pkg::BURST_ON_THE_FLY, dwb_pkg::ORG_X16, 2'h3, 2'h3, 7'b1100001, 4'h8, 8);
   endtask : t_otf_eight
   task automatic t_otf_chop(); run(dwb_pkg::BURST_ON_THE_FLY, dwb_pkg::ORG_X16, 2'h3, 2'h3, 7'b1000001, 4'h8, 4);
   endtask : t_otf_chop
   task automatic t_chop(); run(dwb_pkg::BURST_FIXED_CHOP, dwb_pkg::ORG_X16, 2'h3, 2'h3, 7'b0100000, 4'h4, 4);
   endtask : t_chop
   task automatic t_mask_x8(); run(dwb_pkg::BURST_FIXED_EIGHT, dwb_pkg::ORG_X8, 2'h2, 2'h0, 7'b0010010, 4'h8, 8);
   endtask : t_mask_x8
   task automatic t_mask_x16(); run(dwb_pkg::BURST_FIXED_EIGHT, dwb_pkg::ORG_X16, 2'h1, 2'h1, 7'b0010000, 4'h8, 8);
   endtask : t_mask_x16
   task automatic t_mask_x4(); run(dwb_pkg::BURST_FIXED_CHOP, dwb_pkg::ORG_X4, 2'h0, 2'h1, 7'b0010010, 4'h4, 4);
   endtask : t_mask_x4
   task automatic t_dbi(); run(dwb_pkg::BURST_FIXED_CHOP, dwb_pkg::ORG_X16, 2'h0, 2'h3, 7'b0011010, 4'h4, 4);
   endtask : t_dbi
   task automatic t_tstb(); run(dwb_pkg::BURST_FIXED_CHOP, dwb_pkg::ORG_X16, 2'h0, 2'h3, 7'b0010100, 4'h4, 4);
   endtask : t_tstb

   // additive latency of ten stretches the write latency to nineteen
   task automatic t_al();
      additive_latency <= 5'h0a;
      run(dwb_pkg::BURST_ON_THE_FLY, dwb_pkg::ORG_X16, 2'h3, 2'h3, 7'b0100000, 4'h8, 8);
      additive_latency <= 5'h00;
   endtask : t_al

   // stalled array: buffer fills, later beats are dropped, then drains
   task automatic t_overflow();
      arr_ready <= 1'b0;
      run(dwb_pkg::BURST_FIXED_EIGHT, dwb_pkg::ORG_X16, 2'h3, 2'h3, 7'b0000000, 4'h8, 0);
      check(overflow_r, 1'b1);
      arr_ready <= 1'b1;
      repeat (4) @(posedge clk);
      check(n_got, 2);
      check(arr_valid, 1'b0);
   endtask : t_overflow

   ////////////////////////////////////////////////////////////////////////////
   // reset, scenarios and verdict
   initial begin
      {rst_n, wr_cmd, addr_a10, addr_a12, m_go, mask_enable, bus_inversion_enable} = '0;
      {termination_strobe_enable, crc_enable, burst_mode, org_width, m_mask, m_n} = '0;
      {cmd_bank, cmd_col, m_base, exp_lane} = '0;
      arr_ready = 1'b1;
      additive_latency = 5'h00;
      cas_write_latency = 5'h09;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      check({busy_r, arr_valid, overflow_r, precharge_start_r}, 4'h0);
      @(posedge clk);
      t_eight();
      t_otf_eight();
      t_otf_chop();
      t_chop();
      t_mask_x8();
      t_mask_x16();
      t_mask_x4();
      t_dbi();
      t_tstb();
      t_al();
      t_overflow();
      end_sim();
   end

   // watchdog well beyond the expected run
   initial begin
      #400000;
      n_errors++;
      end_sim();
   end
endmodule : tb

bind dwb_write_path dwb_wp_properties chk_u (.clk(clk), .rst_n(rst_n), .org_width(org_width),
   .mask_enable(mask_enable), .bus_inversion_enable(bus_inversion_enable),
   .termination_strobe_enable(termination_strobe_enable), .crc_enable(crc_enable), .wr_cmd(wr_cmd),
   .addr_a10(addr_a10), .cmd_bank(cmd_bank), .arr_valid(arr_valid), .arr_ready(arr_ready), .arr_col(arr_col),
   .arr_lane_en(arr_lane_en), .precharge_start_r(precharge_start_r), .precharge_bank_r(precharge_bank_r),
   .burst_done_r(burst_done_r), .busy_r(busy_r), .overflow_r(overflow_r), .crc_persistent_r(crc_persistent_r));
